// >>> hw/tsr_pkg.sv
// package: constants for the serial temperature readout block
`default_nettype none
package tsr_pkg;
  localparam int TSR_WORD_W = 16;
  localparam int TSR_TEMP_W = 14;
  localparam int TSR_CMD_W = 8;
  localparam int TSR_RX_BITS = 16;
  localparam int TSR_CNT_W = 6;
  localparam logic [5:0] TSR_TX_LAST = 6'h0F;
  localparam logic [5:0] TSR_ACC_END = 6'h20;
  localparam logic [5:0] TSR_TX_DONE = 6'h10;
  localparam logic [5:0] TSR_CMD_CNT = 6'h18;
  localparam logic [1:0] TSR_PAD_ONES = 2'h3;
  localparam logic [7:0] TSR_CMD_SHUTDOWN = 8'hFF;
  localparam logic [7:0] TSR_CMD_CONTINUOUS = 8'h00;
  localparam logic [15:0] TSR_WORD_RESET = 16'h0003;
  localparam real TSR_LSB_DEG_C = 0.03125;
  // arbitrary neutral identity value
  localparam logic [13:0] TSR_ID_DEFAULT = 14'h2A5C;
  typedef enum logic [1:0] {
    TSR_MODE_CONT = 2'b01,
    TSR_MODE_SHDN = 2'b10
  } tsr_mode_t;
endpackage : tsr_pkg
`default_nettype wire

// >>> hw/tsr_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/10ps
`default_nettype none
module tsr_sync
  import tsr_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)(
  input wire logic clk_i,   // system clock
  input wire logic rst_n_i, // sync reset
  input wire logic d_i,     // async input
  output logic q_o          // synchronised
);
  logic s1_ff;
  logic s2_ff;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
    end
  end
  assign q_o = s2_ff;
endmodule : tsr_sync
`default_nettype wire

// >>> hw/tsr_serial_regs.sv
// serial readout and mode control of the temperature sensor
// Operation
// - temperature is a 14-bit two's complement value, 0.03125 C per step
// - temperature sits in bits 15..2; bits 1..0 always read one
// - read word shifts out msb first
// - low config byte all ones selects shutdown
// - config all zeros selects continuous conversion
// - reads and writes keep working during shutdown
// - shutdown reads return the fixed identity word
// - identity data in bits 15..2, bits 1..0 read one
// - three registers: temperature and identity read-only, config write-only
// - access is 16 clocks out then 16 clocks in
// - output changes on falling edge, input sampled on rising edge
// - only the last eight bits received before deselect count
// - reset loads the temperature word 0x0003, clears the other registers and selects continuous conversion
`timescale 1ns/10ps
`default_nettype none
module tsr_serial_regs
  import tsr_pkg::*;
#(
  parameter logic [TSR_TEMP_W-1:0] ID_CODE = TSR_ID_DEFAULT // arbitrary value
)(
  input wire logic clk_i,                        // 10 MHz system clock
  input wire logic rst_n_i,                      // sync reset, active low
  input wire logic serial_clock_in_i,            // serial clock from master
  input wire logic cs_n_i,                       // chip select, active low
  input wire logic sio_i,                        // data line level in
  output logic sio_o,                            // data line drive value
  output logic sio_oe_o,                         // data line drive enable
  input wire logic [TSR_TEMP_W-1:0] temp_code_i, // converter result
  input wire logic temp_valid_i,                 // conversion done pulse
  output logic shutdown_o                        // shutdown mode active
);
  // each pin crosses into clk_i through two flops
  logic sck_s;
  logic cs_n_s;
  logic sio_s;
  tsr_sync #(.RST_VAL(1'b0)) u_sck (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(serial_clock_in_i), .q_o(sck_s));
  tsr_sync #(.RST_VAL(1'b1)) u_cs (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(cs_n_i), .q_o(cs_n_s));
  tsr_sync #(.RST_VAL(1'b0)) u_sio (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .d_i(sio_i), .q_o(sio_s));

  // state registers and their next values
  logic sck_d_ff, cs_d_ff;
  logic [TSR_WORD_W-1:0] temp_ff, nxt_temp;
  logic [TSR_WORD_W-1:0] tx_ff, nxt_tx;
  logic [TSR_CMD_W-1:0] rx_ff, nxt_rx;
  logic [TSR_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic sio_ff, nxt_sio;
  logic oe_ff, nxt_oe;
  tsr_mode_t mode_ff, nxt_mode;
  logic rise, fall, sel, desel, active;

  // edge detect one flop behind; reset levels equal the idle pins
  assign rise = sck_s & ~sck_d_ff;
  assign fall = ~sck_s & sck_d_ff;
  assign sel = ~cs_n_s & cs_d_ff;
  assign desel = cs_n_s & ~cs_d_ff;
  assign active = ~cs_n_s;

  always_comb
  begin
    nxt_temp = temp_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_cnt = cnt_ff;
    nxt_sio = sio_ff;
    nxt_oe = oe_ff;
    nxt_mode = mode_ff;
    // a conversion may finish mid access; only the stored word moves
    if (temp_valid_i)
      nxt_temp = {temp_code_i, TSR_PAD_ONES};
    if (sel)
    begin
      if (mode_ff == TSR_MODE_SHDN)
        nxt_tx = {ID_CODE, TSR_PAD_ONES};
      else
        nxt_tx = temp_ff;
      // first bit goes out at select, before any clock
      nxt_sio = nxt_tx[TSR_WORD_W-1];
      nxt_oe = 1'b1;
      nxt_cnt = '0;
    end
    else if (desel)
    begin
      nxt_oe = 1'b0;
      // fewer than eight write bits leave stale command bits: ignore them
      if (cnt_ff >= TSR_CMD_CNT)
      begin
        // other codes leave the mode alone; no test mode modelled
        if (rx_ff == TSR_CMD_SHUTDOWN)
          nxt_mode = TSR_MODE_SHDN;
        else if (rx_ff == TSR_CMD_CONTINUOUS)
          nxt_mode = TSR_MODE_CONT;
      end
    end
    else if (active)
    begin
      if (rise && cnt_ff != TSR_ACC_END)
      begin
        nxt_cnt = cnt_ff + 6'h01;
        if (cnt_ff > TSR_TX_LAST)
          nxt_rx = {rx_ff[TSR_CMD_W-2:0], sio_s};
      end
      if (fall && cnt_ff <= TSR_TX_LAST && cnt_ff != '0)
      begin
        nxt_tx = {tx_ff[TSR_WORD_W-2:0], 1'b1};
        nxt_sio = nxt_tx[TSR_WORD_W-1];
      end
      // the master owns the line from this falling edge on
      if (fall && cnt_ff == TSR_TX_DONE)
        nxt_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      temp_ff <= TSR_WORD_RESET;
      tx_ff <= '0;
      rx_ff <= '0;
      cnt_ff <= '0;
      sio_ff <= 1'b0;
      oe_ff <= 1'b0;
      mode_ff <= TSR_MODE_CONT;
    end
    else
    begin
      sck_d_ff <= sck_s;
      cs_d_ff <= cs_n_s;
      temp_ff <= nxt_temp;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      cnt_ff <= nxt_cnt;
      sio_ff <= nxt_sio;
      oe_ff <= nxt_oe;
      mode_ff <= nxt_mode;
    end
  end

  assign sio_o = sio_ff;
  assign sio_oe_o = oe_ff;
  assign shutdown_o = (mode_ff == TSR_MODE_SHDN);

  // protocol checks
  chk_mode_reset: assert property (@(posedge clk_i)
    !rst_n_i |=> mode_ff == TSR_MODE_CONT)
    else $error("mode not continuous after reset");
  chk_mode_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !desel |=> $stable(mode_ff))
    else $error("mode changed without deselect");
  chk_tx_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel && mode_ff == TSR_MODE_SHDN |=> tx_ff == {ID_CODE, TSR_PAD_ONES})
    else $error("identity word not loaded");
  chk_tx_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    active && !sel && !fall |=> $stable(tx_ff))
    else $error("read word changed mid access");
  chk_pad_ones: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    temp_ff[1:0] == TSR_PAD_ONES)
    else $error("pad bits not ones");
  chk_oe_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel |=> sio_oe_o && sio_o == tx_ff[TSR_WORD_W-1])
    else $error("first bit not driven at select");
  chk_oe_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_s && cs_d_ff |-> !sio_oe_o)
    else $error("line driven while deselected");
  chk_shdn_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desel && cnt_ff == TSR_ACC_END && rx_ff == TSR_CMD_SHUTDOWN
    |=> shutdown_o)
    else $error("shutdown not entered");
  chk_cont_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desel && cnt_ff == TSR_ACC_END && rx_ff == TSR_CMD_CONTINUOUS
    |=> !shutdown_o)
    else $error("continuous not entered");
  chk_shift_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    active && !sel && fall && cnt_ff != '0 && cnt_ff <= TSR_TX_LAST
    |=> sio_o == $past(tx_ff[TSR_WORD_W-2]))
    else $error("read bit out of order");
  chk_oe_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    active && !sel && fall && cnt_ff == TSR_TX_DONE |=> !sio_oe_o)
    else $error("line not released after read phase");
  chk_rx_sample: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    active && !sel && rise && cnt_ff > TSR_TX_LAST && cnt_ff != TSR_ACC_END
    |=> rx_ff[0] == $past(sio_s))
    else $error("write bit not taken on rising edge");
  chk_short_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desel && cnt_ff < TSR_CMD_CNT |=> $stable(mode_ff))
    else $error("mode changed by short write");
  chk_cnt_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_ff <= TSR_ACC_END)
    else $error("clock count past access end");
  chk_temp_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    temp_valid_i |=> temp_ff[TSR_WORD_W-1 -: TSR_TEMP_W] == $past(temp_code_i))
    else $error("temperature code not stored");
  chk_read_temp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sel && mode_ff == TSR_MODE_CONT |=> tx_ff == $past(temp_ff))
    else $error("temperature word not loaded");
  chk_desel_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desel |=> !sio_oe_o)
    else $error("line kept after deselect");

  // main scenarios
  cov_full: cover property (@(posedge clk_i) desel && cnt_ff == TSR_ACC_END);
  cov_shdn: cover property (@(posedge clk_i) $rose(shutdown_o));
  cov_short: cover property (@(posedge clk_i) desel && cnt_ff <= TSR_TX_LAST);
  cov_byte: cover property (@(posedge clk_i) desel && cnt_ff == TSR_CMD_CNT);
  cov_wake: cover property (@(posedge clk_i) $fell(shutdown_o));
endmodule : tsr_serial_regs
`default_nettype wire

// >>> verification/tsr_bus_master.sv
// serial bus master model driving the sensor readout
`timescale 1ns/10ps
`default_nettype none
module tsr_bus_master (
  input wire logic clk_i, // system clock
  input wire logic sio_i, // resolved data line
  output logic sck_o = 1'b0, // serial clock, idles low
  output logic cs_n_o = 1'b1, // chip select
  output logic sio_o = 1'b0, // write data
  output logic sio_oe_o = 1'b0 // write data enable
);
  // nr + nw clocks; read bits taken on the first 16, nw bits of wd written from clock 16 on, msb first
  task automatic xfer(input int nr, input int nw, input logic [15:0] wd,
                      output logic [15:0] rd);
    rd = 16'h0000;
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < nr + nw; i++)
    begin
      if (i >= 16)
      begin
        sio_oe_o <= 1'b1;
        sio_o <= wd[nw - 1 - (i - 16)];
      end
      repeat (4) @(posedge clk_i);
      if (i < 16)
        rd = {rd[14:0], sio_i};
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    sio_oe_o <= 1'b0;
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : xfer
endmodule : tsr_bus_master
`default_nettype wire

// >>> verification/tb_tsr_serial_regs.sv
// bench for the serial temperature readout block
`timescale 1ns/10ps
`default_nettype none
module tb_tsr_serial_regs;
  import tsr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [13:0] code = 14'h0000;
  logic vld = 1'b0;
  logic sio_q = 1'b0;
  logic sck, cs_n, d_sio, d_oe, m_sio, m_oe, shdn;
  int n_fail = 0;
  int total_checks = 0;
  // released line shows the inverse of its last driven level
  wire logic sio = d_oe ? d_sio : (m_oe ? m_sio : ~sio_q);
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (d_oe || m_oe)
      sio_q <= sio;
  tsr_serial_regs u_tsr_serial_regs (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .serial_clock_in_i(sck), .cs_n_i(cs_n), .sio_i(sio), .sio_o(d_sio),
    .sio_oe_o(d_oe), .temp_code_i(code), .temp_valid_i(vld), .shutdown_o(shdn));
  tsr_bus_master u_tsr_bus_master (.clk_i(clk_i), .sio_i(sio), .sck_o(sck),
    .cs_n_o(cs_n), .sio_o(m_sio), .sio_oe_o(m_oe));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic load(input logic [13:0] c);
    code <= c;
    vld <= 1'b1;
    @(posedge clk_i);
    vld <= 1'b0;
    @(posedge clk_i);
  endtask : load
  task automatic t_reset;
    logic [15:0] rd;
    chk("mode", 16'h0000, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 16, 16'h0000, rd);
    chk("reset word", TSR_WORD_RESET, rd);
  endtask : t_reset
  task automatic t_temp;
    logic [15:0] rd;
    load(14'h0320);
    u_tsr_bus_master.xfer(16, 0, 16'h0000, rd);
    chk("positive", 16'h0C83, rd);
    load(14'h3FFF);
    u_tsr_bus_master.xfer(16, 0, 16'h0000, rd);
    chk("negative", 16'hFFFF, rd);
  endtask : t_temp
  task automatic t_hold;
    logic [15:0] rd;
    load(14'h0320);
    fork
      u_tsr_bus_master.xfer(16, 0, 16'h0000, rd);
      begin
        repeat (40) @(posedge clk_i);
        load(14'h1000);
      end
    join
    chk("held word", 16'h0C83, rd);
    u_tsr_bus_master.xfer(16, 0, 16'h0000, rd);
    chk("next word", 16'h4003, rd);
  endtask : t_hold
  task automatic t_shdn;
    logic [15:0] rd;
    u_tsr_bus_master.xfer(16, 16, 16'h12FF, rd);
    chk("to shutdown", 16'h0001, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 8, 16'h0000, rd);
    chk("identity", {TSR_ID_DEFAULT, TSR_PAD_ONES}, rd);
    chk("byte wake", 16'h0000, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 8, 16'h00FF, rd);
    chk("awake word", 16'h4003, rd);
    chk("byte shutdown", 16'h0001, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 4, 16'h0000, rd);
    chk("shutdown read", {TSR_ID_DEFAULT, TSR_PAD_ONES}, rd);
    chk("short write", 16'h0001, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 16, 16'h0000, rd);
    chk("to continuous", 16'h0000, {15'h0, shdn});
    u_tsr_bus_master.xfer(4, 0, 16'h0000, rd);
    chk("nibble", 16'h0004, {12'h000, rd[3:0]});
    chk("mode kept", 16'h0000, {15'h0, shdn});
  endtask : t_shdn
  task automatic t_rerun;
    logic [15:0] rd;
    u_tsr_bus_master.xfer(16, 16, 16'hFFFF, rd);
    chk("before reset", 16'h0001, {15'h0, shdn});
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("mode after reset", 16'h0000, {15'h0, shdn});
    u_tsr_bus_master.xfer(16, 0, 16'h0000, rd);
    chk("word after reset", TSR_WORD_RESET, rd);
  endtask : t_rerun
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_temp();
    t_hold();
    t_shdn();
    t_rerun();
    print_verdict();
  end
  initial
  begin
    repeat (50000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
endmodule : tb_tsr_serial_regs
`default_nettype wire
